// file: hw/cgp_top.sv
// configurable gpio port with an axi4-lite register slave
// assumes pads and internal functions are synchronous-free levels
// and one clock aclk at 200 MHz with a synchronous reset
`timescale 1ns/10ps
`default_nettype none
module cgp_top
  import cgp_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic                    s_axi_awvalid,
  output var  logic                    s_axi_awready,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  // axi4-lite write data
  input  wire logic                    s_axi_wvalid,
  output var  logic                    s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // axi4-lite write response
  output var  logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output var  logic [1:0]              s_axi_bresp,
  // axi4-lite read address
  input  wire logic                    s_axi_arvalid,
  output var  logic                    s_axi_arready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  // axi4-lite read data
  output var  logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output var  logic [31:0]             s_axi_rdata,
  output var  logic [1:0]              s_axi_rresp,
  // pad side
  input  wire logic [CGP_NUM_PADS-1:0] pad_in,
  output var  logic [CGP_NUM_PADS-1:0] pad_out,
  output var  logic [CGP_NUM_PADS-1:0] pad_oe,
  // internal alternative functions
  input  wire logic [CGP_NUM_PADS-1:0] alt_out,
  input  wire logic [CGP_NUM_PADS-1:0] alt_oe,
  input  wire logic [CGP_NUM_PADS-1:0] i2c_drive_low,
  output var  logic [CGP_NUM_PADS-1:0] alt_in,
  // events
  output var  logic                    irq,
  output var  logic                    wake_req
);

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  localparam int N = CGP_NUM_PADS;

  // bus holding registers
  logic              aw_held_ff;   // write address captured
  logic [7:0]        awaddr_ff;    // captured write address
  logic              w_held_ff;    // write data captured
  logic [31:0]       wdata_ff;     // captured write data
  logic [3:0]        wstrb_ff;     // captured byte strobes
  logic              awready_ff;   // address channel ready
  logic              wready_ff;    // data channel ready
  logic              bvalid_ff;    // write response pending
  logic [1:0]        bresp_ff;     // write response code
  logic              arready_ff;   // read address ready
  logic              rvalid_ff;    // read data pending
  logic [31:0]       rdata_ff;     // read data
  logic [1:0]        rresp_ff;     // read response code

  // software registers
  logic [N-1:0]      dir_ff;       // 1 = output
  logic [N-1:0]      alt_sel_ff;   // 1 = alternative function
  logic [N-1:0]      i2c_sel_ff;   // 1 = i2c function
  logic [N-1:0]      out_val_ff;   // level to drive
  logic [N-1:0]      rise_en_ff;   // rising edge irq enable
  logic [N-1:0]      fall_en_ff;   // falling edge irq enable
  logic [N-1:0]      irq_stat_ff;  // sticky irq status
  logic [N-1:0]      irq_mask_ff;  // irq enables
  logic [N-1:0]      wake_en_ff;   // wake enables
  logic [N-1:0]      wake_stat_ff; // sticky wake status

  // pad and output registers
  logic [N-1:0]      pad_out_ff;   // pad level
  logic [N-1:0]      pad_oe_ff;    // pad drive enable
  logic [N-1:0]      alt_in_ff;    // level to internal functions
  logic              irq_ff;       // interrupt level
  logic              wake_ff;      // wake request level

  // pad-side wires
  logic [N-1:0]      pad_sync;     // synchronised pad level
  logic [N-1:0]      pad_rise;     // one-cycle rising pulse
  logic [N-1:0]      pad_fall;     // one-cycle falling pulse
  logic [N-1:0]      role_i2c;     // pad owned by i2c
  logic [N-1:0]      role_alt;     // pad owned by alt function
  logic [N-1:0]      role_out;     // pad is a gpio output
  logic [N-1:0]      role_in;      // pad is a gpio input
  logic [N-1:0]      nxt_pad_out;  // next pad level
  logic [N-1:0]      nxt_pad_oe;   // next pad enable
  logic [N-1:0]      irq_event;    // interrupt event per pad
  logic [N-1:0]      wake_event;   // wake event per pad
  logic [N-1:0]      nxt_irq_stat; // next irq status
  logic [N-1:0]      nxt_wake_stat;// next wake status

  // -------------------------------------------------------------
  // byte-lane merge of a register write
  // -------------------------------------------------------------
  function automatic logic [N-1:0] merge_wr
  (
    input logic [N-1:0] old_val,
    input logic [31:0]  data,
    input logic [3:0]   strb
  );
    logic [31:0] lane_mask;
    logic [31:0] result;
    begin
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      result    = ({{CGP_ZERO_BITS{1'b0}}, old_val} & ~lane_mask)
                | (data & lane_mask);
      merge_wr  = result[N-1:0];
    end
  endfunction

  // -------------------------------------------------------------
  // write channel control
  // -------------------------------------------------------------
  wire aw_take   = s_axi_awvalid && awready_ff;
  wire w_take    = s_axi_wvalid && wready_ff;
  wire do_write  = aw_held_ff && w_held_ff && !bvalid_ff;
  wire b_done    = bvalid_ff && s_axi_bready;
  wire nxt_aw_hd = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_held_ff);
  wire nxt_w_hd  = w_take ? 1'b1 : (do_write ? 1'b0 : w_held_ff);

  // write address decode
  wire wr_dir   = do_write && (awaddr_ff == CGP_OFS_DIR);
  wire wr_alt   = do_write && (awaddr_ff == CGP_OFS_ALT_SEL);
  wire wr_i2c   = do_write && (awaddr_ff == CGP_OFS_I2C_SEL);
  wire wr_oval  = do_write && (awaddr_ff == CGP_OFS_OUT_VAL);
  wire wr_rise  = do_write && (awaddr_ff == CGP_OFS_RISE_EN);
  wire wr_fall  = do_write && (awaddr_ff == CGP_OFS_FALL_EN);
  wire wr_mask  = do_write && (awaddr_ff == CGP_OFS_IRQ_MASK);
  wire wr_wake  = do_write && (awaddr_ff == CGP_OFS_WAKE_EN);
  // read-only and read-clear registers ignore writes but answer okay
  wire wr_ro    = (awaddr_ff == CGP_OFS_IN_VAL)
               || (awaddr_ff == CGP_OFS_IRQ_STAT)
               || (awaddr_ff == CGP_OFS_WAKE_STAT);
  wire wr_hit   = wr_dir || wr_alt || wr_i2c || wr_oval || wr_rise
               || wr_fall || wr_mask || wr_wake || (do_write && wr_ro);

  // capture address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
    end
    else
    begin
      aw_held_ff <= nxt_aw_hd;
      w_held_ff  <= nxt_w_hd;
      awready_ff <= !nxt_aw_hd;
      wready_ff  <= !nxt_w_hd;
      if (aw_take)
        awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // write response, slverr for an unmapped offset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= CGP_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? CGP_RESP_OKAY : CGP_RESP_SLVERR;
    end
    else if (b_done)
      bvalid_ff <= 1'b0;
  end

  // -------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------
  // shared pads reset to their interface
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dir_ff      <= CGP_RST_ZERO;
      alt_sel_ff  <= CGP_RST_ALT_SEL;
      i2c_sel_ff  <= CGP_RST_ZERO;
      out_val_ff  <= CGP_RST_ZERO;
      rise_en_ff  <= CGP_RST_ZERO;
      fall_en_ff  <= CGP_RST_ZERO;
      irq_mask_ff <= CGP_RST_ZERO;
      wake_en_ff  <= CGP_RST_ZERO;
    end
    else
    begin
      if (wr_dir)
        dir_ff <= merge_wr(dir_ff, wdata_ff, wstrb_ff);
      if (wr_alt)
        alt_sel_ff <= merge_wr(alt_sel_ff, wdata_ff, wstrb_ff);
      if (wr_i2c)
        i2c_sel_ff <= merge_wr(i2c_sel_ff, wdata_ff, wstrb_ff)
                    & CGP_I2C_CAPABLE;
      if (wr_oval)
        out_val_ff <= merge_wr(out_val_ff, wdata_ff, wstrb_ff);
      if (wr_rise)
        rise_en_ff <= merge_wr(rise_en_ff, wdata_ff, wstrb_ff);
      if (wr_fall)
        fall_en_ff <= merge_wr(fall_en_ff, wdata_ff, wstrb_ff);
      if (wr_mask)
        irq_mask_ff <= merge_wr(irq_mask_ff, wdata_ff, wstrb_ff);
      // wake enables stick on capable pads
      if (wr_wake)
        wake_en_ff <= merge_wr(wake_en_ff, wdata_ff, wstrb_ff)
                    & CGP_WAKE_CAPABLE;
    end
  end

  // -------------------------------------------------------------
  // read channel
  // -------------------------------------------------------------
  wire       ar_take  = s_axi_arvalid && arready_ff;
  wire [7:0] rd_addr  = {s_axi_araddr[7:2], 2'h0};
  wire       nxt_rv   = ar_take ? 1'b1
                      : ((rvalid_ff && s_axi_rready) ? 1'b0 : rvalid_ff);

  // read address decode
  wire rd_dir   = (rd_addr == CGP_OFS_DIR);
  wire rd_alt   = (rd_addr == CGP_OFS_ALT_SEL);
  wire rd_i2c   = (rd_addr == CGP_OFS_I2C_SEL);
  wire rd_oval  = (rd_addr == CGP_OFS_OUT_VAL);
  wire rd_ival  = (rd_addr == CGP_OFS_IN_VAL);
  wire rd_rise  = (rd_addr == CGP_OFS_RISE_EN);
  wire rd_fall  = (rd_addr == CGP_OFS_FALL_EN);
  wire rd_stat  = (rd_addr == CGP_OFS_IRQ_STAT);
  wire rd_mask  = (rd_addr == CGP_OFS_IRQ_MASK);
  wire rd_wen   = (rd_addr == CGP_OFS_WAKE_EN);
  wire rd_wstat = (rd_addr == CGP_OFS_WAKE_STAT);
  wire rd_hit   = rd_dir || rd_alt || rd_i2c || rd_oval || rd_ival
               || rd_rise || rd_fall || rd_stat || rd_mask || rd_wen
               || rd_wstat;

  // read data select, unmapped reads return zero
  // input value is the synchronised pad level
  // output value reads back what was set
  wire [N-1:0] rd_sel = rd_dir   ? dir_ff
                      : rd_alt   ? alt_sel_ff
                      : rd_i2c   ? i2c_sel_ff
                      : rd_oval  ? out_val_ff
                      : rd_ival  ? pad_sync
                      : rd_rise  ? rise_en_ff
                      : rd_fall  ? fall_en_ff
                      : rd_stat  ? irq_stat_ff
                      : rd_mask  ? irq_mask_ff
                      : rd_wen   ? wake_en_ff
                      : rd_wstat ? wake_stat_ff
                      : CGP_RST_ZERO;

  // read clear strobes
  wire clr_irq  = ar_take && rd_stat;
  wire clr_wake = ar_take && rd_wstat;

  // latch read data on the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= CGP_RESP_OKAY;
    end
    else
    begin
      arready_ff <= !nxt_rv;
      rvalid_ff  <= nxt_rv;
      if (ar_take)
      begin
        rdata_ff <= {{CGP_ZERO_BITS{1'b0}}, rd_sel};
        rresp_ff <= rd_hit ? CGP_RESP_OKAY : CGP_RESP_SLVERR;
      end
    end
  end

  // -------------------------------------------------------------
  // pad input conditioning
  // -------------------------------------------------------------
  // two flops before any use
  cgp_sync #(
    .WIDTH    (N)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  // edge pulses from the synchronised level
  cgp_edge #(
    .WIDTH    (N)
  ) u_edge (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .level_in (pad_sync),
    .rise_out (pad_rise),
    .fall_out (pad_fall)
  );

  // -------------------------------------------------------------
  // per-pad role and drive
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_pad
      assign role_i2c[gi] = i2c_sel_ff[gi] && CGP_I2C_CAPABLE[gi];
      assign role_alt[gi] = alt_sel_ff[gi] && !role_i2c[gi];
      assign role_out[gi] = dir_ff[gi] && !alt_sel_ff[gi] && !role_i2c[gi];
      assign role_in[gi]  = !role_i2c[gi] && !role_alt[gi] && !role_out[gi];
      assign nxt_pad_out[gi] = role_alt[gi] ? alt_out[gi]
                             : role_out[gi] ? out_val_ff[gi]
                             : 1'b0;
      assign nxt_pad_oe[gi]  = role_i2c[gi] ? i2c_drive_low[gi]
                             : role_alt[gi] ? alt_oe[gi]
                             : role_out[gi];
      assign irq_event[gi]  = role_in[gi]
                           && ((pad_rise[gi] && rise_en_ff[gi])
                           ||  (pad_fall[gi] && fall_en_ff[gi]));
      assign wake_event[gi] = role_in[gi] && wake_en_ff[gi]
                           && CGP_WAKE_CAPABLE[gi]
                           && (pad_rise[gi] || pad_fall[gi]);
    end
  endgenerate

  // sticky status, a new event wins over the read clear
  assign nxt_irq_stat  = (irq_stat_ff & ~{N{clr_irq}}) | irq_event;
  assign nxt_wake_stat = (wake_stat_ff & ~{N{clr_wake}}) | wake_event;

  // pad, status and event registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_out_ff   <= CGP_RST_ZERO;
      pad_oe_ff    <= CGP_RST_ZERO;
      alt_in_ff    <= CGP_RST_ZERO;
      irq_stat_ff  <= CGP_RST_ZERO;
      wake_stat_ff <= CGP_RST_ZERO;
      irq_ff       <= 1'b0;
      wake_ff      <= 1'b0;
    end
    else
    begin
      pad_out_ff   <= nxt_pad_out;
      pad_oe_ff    <= nxt_pad_oe;
      alt_in_ff    <= pad_sync;
      irq_stat_ff  <= nxt_irq_stat;
      wake_stat_ff <= nxt_wake_stat;
      irq_ff       <= |(nxt_irq_stat & irq_mask_ff);
      wake_ff      <= |nxt_wake_stat;
    end
  end

  // -------------------------------------------------------------
  // output ports
  // -------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign pad_out       = pad_out_ff;
  assign pad_oe        = pad_oe_ff;
  assign alt_in        = alt_in_ff;
  assign irq           = irq_ff;
  assign wake_req      = wake_ff;

endmodule
`default_nettype wire

// file: hw/cgp_pkg.sv
// constants, register map and field masks of the gpio port
// assumes one 200 MHz clock and a 32-bit axi4-lite register bus
//
// Summary of operation
// - each pad takes exactly one role
// - input pads read the sensed pad level
// - output pads drive and read back value
// - alternative function owns direction and level
// - input pads raise interrupts on chosen edges
// - only pads one, four, five, eight wake
// - outputs except i2c pads drive both levels actively
// - shared pads default to their other function
// - primary pads one to ten select i2c
package cgp_pkg;

  // -------------------------------------------------------------
  // pad population
  // -------------------------------------------------------------
  localparam int CGP_NUM_PADS  = 28;           // ten primary, 18 shared
  localparam int CGP_ZERO_BITS = 32 - CGP_NUM_PADS;  // read-back fill

  // pads that may wake the module: one, four, five and eight
  localparam logic [CGP_NUM_PADS-1:0] CGP_WAKE_CAPABLE = 28'h0000099;
  // primary pads one to ten may be handed to the i2c function
  localparam logic [CGP_NUM_PADS-1:0] CGP_I2C_CAPABLE  = 28'h00003ff;

  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [7:0] CGP_OFS_DIR       = 8'h00; // 1 = output
  localparam logic [7:0] CGP_OFS_ALT_SEL   = 8'h04; // 1 = alt function
  localparam logic [7:0] CGP_OFS_I2C_SEL   = 8'h08; // 1 = i2c function
  localparam logic [7:0] CGP_OFS_OUT_VAL   = 8'h0c; // driven level
  localparam logic [7:0] CGP_OFS_IN_VAL    = 8'h10; // sensed level, ro
  localparam logic [7:0] CGP_OFS_RISE_EN   = 8'h14; // irq on rising
  localparam logic [7:0] CGP_OFS_FALL_EN   = 8'h18; // irq on falling
  localparam logic [7:0] CGP_OFS_IRQ_STAT  = 8'h1c; // sticky, read clears
  localparam logic [7:0] CGP_OFS_IRQ_MASK  = 8'h20; // 1 = enabled
  localparam logic [7:0] CGP_OFS_WAKE_EN   = 8'h24; // wake enables
  localparam logic [7:0] CGP_OFS_WAKE_STAT = 8'h28; // sticky, read clears

  // -------------------------------------------------------------
  // values after reset
  // -------------------------------------------------------------
  localparam logic [CGP_NUM_PADS-1:0] CGP_RST_ZERO    = 28'h0000000;
  // shared pads start on their initial interface
  localparam logic [CGP_NUM_PADS-1:0] CGP_RST_ALT_SEL = 28'hffffc00;

  // -------------------------------------------------------------
  // bus answers
  // -------------------------------------------------------------
  localparam logic [1:0] CGP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CGP_RESP_SLVERR = 2'h2;

endpackage

// file: hw/cgp_sync.sv
// two-stage synchroniser for a vector of pad inputs
// assumes every bit is an independent level
`timescale 1ns/10ps
`default_nettype none
module cgp_sync
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;   // first stage, read by second only

  // -------------------------------------------------------------
  // two flops in series
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff  <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// file: hw/cgp_edge.sv
// rising and falling edge pulses of synchronised levels
// assumes inputs already synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module cgp_edge
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] level_in,
  output var  logic [WIDTH-1:0] rise_out,
  output var  logic [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] prev_ff;    // level one cycle ago
  logic             primed_ff;  // prev_ff holds a real sample

  // -------------------------------------------------------------
  // edge pulses, suppressed until the first sample is taken
  // -------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_ff   <= '0;
      primed_ff <= 1'b0;
      rise_out  <= '0;
      fall_out  <= '0;
    end
    else
    begin
      prev_ff   <= level_in;
      primed_ff <= 1'b1;
      rise_out  <= primed_ff ? (level_in & ~prev_ff) : '0;
      fall_out  <= primed_ff ? (~level_in & prev_ff) : '0;
    end
  end

endmodule
`default_nettype wire

// file: sim/cgp_pad_dev.sv
// pad-side device model: drives every pad the port leaves free
// assumes push-pull pads and no pull resistors on the board
`timescale 1ns/10ps
`default_nettype none
module cgp_pad_dev
  import cgp_pkg::*;
(
  input  wire logic [CGP_NUM_PADS-1:0] pad_out,
  input  wire logic [CGP_NUM_PADS-1:0] pad_oe,
  input  wire logic [CGP_NUM_PADS-1:0] ext_lvl,
  output var  logic [CGP_NUM_PADS-1:0] pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule
`default_nettype wire

// file: sim/cgp_top_sva.sv
// checker of bus timing, pad sync and wake cause of the gpio port
// assumes it is bound to cgp_top
`timescale 1ns/10ps
`default_nettype none
module cgp_sva
  import cgp_pkg::*;
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [CGP_NUM_PADS-1:0] pad_in,
  input wire logic [CGP_NUM_PADS-1:0] pad_oe,
  input wire logic [CGP_NUM_PADS-1:0] alt_in,
  input wire logic                    irq,
  input wire logic                    wake_req
);
  // cycles since reset, saturating at three
  logic [1:0] age_ff;
  always_ff @(posedge aclk)
    if (!aresetn) age_ff <= 2'h0;
    else if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RST_IDLE: assert property ($rose(aresetn) |->
    pad_oe == '0 && !irq && !wake_req) else $error("not idle");
  AST_SYNC: assert property (age_ff == 2'h3 |->
    alt_in == $past(pad_in, 3)) else $error("sync depth wrong");
  AST_WAKE_CAUSE: assert property ($rose(wake_req) |->
    (($past(alt_in, 1) ^ $past(alt_in, 6)) & CGP_WAKE_CAPABLE) != '0)
    else $error("wake without capable pad edge");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  AST_AR_BUSY: assert property (s_axi_rvalid |->
    !s_axi_arready) else $error("address taken while busy");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("resp dropped");
endmodule
`default_nettype wire

// file: sim/configurable_gpio_port_tb.sv
// self-checking bench of the gpio port with a pad device model
// assumes cgp_top, cgp_pad_dev and cgp_sva compiled before it
`timescale 1ns/10ps
`default_nettype none
module configurable_gpio_port_tb
  import cgp_pkg::*;
;
  localparam int N = CGP_NUM_PADS;
  localparam logic [31:0] ALL = {4'h0, ~CGP_RST_ZERO};
  logic aclk, aresetn, irq, wake_req, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, m [11];
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [N-1:0] pad_in, pad_out, pad_oe, alt_out, alt_oe, alt_in, ext;
  logic [N-1:0] i2c_drive_low;
  int failures = 0, total_checks = 0;

  cgp_top DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .pad_in, .pad_out, .pad_oe, .alt_out, .alt_oe,
    .i2c_drive_low, .alt_in, .irq, .wake_req);
  cgp_pad_dev u_dev (.pad_out, .pad_oe, .ext_lvl(ext), .pad_in);

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // one edge, bounded
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60)
    begin
      failures++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad = 1'b0, dd = 1'b0;
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd))
    begin
      tick(n);
      ad |= s_axi_awvalid & s_axi_awready;
      dd |= s_axi_wvalid & s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !dd;
    end
    do tick(n); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    tick(n);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tick(n);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do tick(n); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    tick(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tick(n);
  endtask

  // write and update the model
  task automatic wm(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'(r), 32'(CGP_RESP_OKAY));
    case (a)
      CGP_OFS_I2C_SEL: m[2] = d & {4'h0, CGP_I2C_CAPABLE};
      CGP_OFS_WAKE_EN: m[9] = d & {4'h0, CGP_WAKE_CAPABLE};
      CGP_OFS_IN_VAL, CGP_OFS_IRQ_STAT, CGP_OFS_WAKE_STAT: ;
      default: m[a[5:2]] = d & ALL;
    endcase
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", 32'(r), 32'(CGP_RESP_OKAY));
  endtask

  // pad drive by role priority i2c, alt, output
  task automatic cp;
    logic [31:0] eo, ev;
    repeat (2) @(posedge aclk);
    eo = (m[2] & i2c_drive_low) | (~m[2] & m[1] & alt_oe)
       | (~m[2] & ~m[1] & m[0]);
    ev = (~m[2] & m[1] & alt_out) | (~m[2] & ~m[1] & m[3]);
    chk("pad_oe", 32'(pad_oe), eo);
    chk("pad_out", 32'(pad_out) & eo, ev & eo);
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial
  begin
    logic [31:0] v, d;
    logic [1:0] r;
    int k;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, alt_out, alt_oe, i2c_drive_low, ext} = '0;
    foreach (m[i]) m[i] = 32'h0;
    m[1] = {4'h0, CGP_RST_ALT_SEL};
    v = $urandom(32'hb7bc);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 11; k++) rc(8'(k * 4), m[k]);
    rd(8'h30, d, r);
    chk("rresp", 32'(r), 32'(CGP_RESP_SLVERR));
    wr(8'h30, 32'h5, r);
    chk("bresp", 32'(r), 32'(CGP_RESP_SLVERR));
    $display("reset and map test done");
    wm(CGP_OFS_ALT_SEL, 32'h0);
    v = $urandom & ALL;
    ext <= v[N-1:0];
    repeat (4) @(posedge aclk);
    rc(CGP_OFS_IN_VAL, v);
    chk("alt_in", 32'(alt_in), v);
    wm(CGP_OFS_OUT_VAL, $urandom);
    wm(CGP_OFS_DIR, $urandom);
    cp();
    rc(CGP_OFS_OUT_VAL, m[3]);
    rc(CGP_OFS_IN_VAL, (m[0] & m[3]) | (~m[0] & v));
    $display("input and output test done");
    alt_out <= N'($urandom);
    alt_oe <= N'($urandom);
    wm(CGP_OFS_ALT_SEL, $urandom);
    cp();
    i2c_drive_low <= N'($urandom);
    wm(CGP_OFS_I2C_SEL, 32'hffffffff);
    cp();
    rc(CGP_OFS_I2C_SEL, m[2]);
    $display("alternative and i2c test done");
    ext <= '0;
    wm(CGP_OFS_I2C_SEL, 32'h0);
    wm(CGP_OFS_ALT_SEL, 32'h0);
    wm(CGP_OFS_DIR, 32'h0);
    repeat (8) @(posedge aclk);
    wm(CGP_OFS_RISE_EN, ALL);
    wm(CGP_OFS_IRQ_MASK, ALL);
    k = $urandom_range(27);
    ext <= N'(1) << k;
    repeat (8) @(posedge aclk);
    chk("irq", 32'(irq), 32'h1);
    rc(CGP_OFS_IRQ_STAT, 32'h1 << k);
    chk("irq", 32'(irq), 32'h0);
    wm(CGP_OFS_IRQ_MASK, 32'h0);
    wm(CGP_OFS_FALL_EN, ALL);
    ext <= '0;
    repeat (8) @(posedge aclk);
    chk("irq", 32'(irq), 32'h0);
    rc(CGP_OFS_IRQ_STAT, 32'h1 << k);
    $display("interrupt test done");
    wm(CGP_OFS_WAKE_EN, ALL);
    rc(CGP_OFS_WAKE_EN, m[9]);
    ext <= '1;
    repeat (8) @(posedge aclk);
    chk("wake_req", 32'(wake_req), 32'h1);
    rc(CGP_OFS_WAKE_STAT, {4'h0, CGP_WAKE_CAPABLE});
    chk("wake_req", 32'(wake_req), 32'h0);
    $display("wake test done");
    finish_test();
  end
endmodule

bind cgp_top cgp_sva u_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pad_in, .pad_oe,
  .alt_in, .irq, .wake_req);
`default_nettype wire
